/* common/dp_diag_map.vh */
// Constants for the diagnostic frame builder: register map, field positions, codes.
// Assumes an 8-bit register port with byte addresses and one core clock.
`ifndef DP_DIAG_MAP_VH
`define DP_DIAG_MAP_VH

////////////////////////////////////////////////////////////////////////////////
// Register map
`define PI_LAST_ADDR 8'h1F
`define REG_CTRL 8'h20
`define REG_BASE 8'h21
`define REG_IRQ_STAT 8'h22
`define REG_IRQ_MASK 8'h23
`define REG_MSG_CODE 8'h24
`define REG_STATE 8'h25

// Control register fields and reset values
`define CTRL_IDENT_LOW_FIRST 0
`define CTRL_RESET 8'h00
`define BASE_RESET 8'h00
`define MASK_RESET 8'h00

// Interrupt status bit positions
`define IRQ_FRAME_SENT 0
`define IRQ_USER_START 1
`define IRQ_USER_DELETE 2
`define IRQ_ERROR 3
`define IRQ_IGNORED 4

////////////////////////////////////////////////////////////////////////////////
// Frame layout
`define FRAME_BYTES 16
`define DEV_LEN_TYPE 8'h0A
`define ST1_FIXED_ONE 8'h04
`define MSG_NONE 8'h00
`define MSG_ERR_FIRST 8'h12
`define MSG_ERR_LAST 8'h17
`define MSG_USER_VALID 8'h40

// Diagnostic status byte
`define STAT_VALID 0
`define STAT_DELETE 1
`define STAT_IGNORED 8'h03
`define BLOCK_BYTES 6

`endif

/* src/diag_frame_tx.v */
// Byte-wise sender of one 16-byte diagnostic frame, byte 0 first.
// Assumes the receiving link takes a byte when valid and ready are both high.
`timescale 1ns/100ps
`default_nettype none
`include "dp_diag_map.vh"

module diag_frame_tx (
    // Clock and reset
    input wire i_core_clk,
    input wire i_rst,
    // Frame to send
    input wire i_start,
    input wire [127:0] i_frame,
    output reg o_busy,
    // Byte stream
    output reg o_valid,
    output reg [7:0] o_data,
    output reg o_last,
    input wire i_ready
);

    reg [127:0] shift_reg;
    reg [3:0] count_reg;

    // Frame is latched at start, so late image writes do not tear a frame
    always @(posedge i_core_clk) begin
        if (i_rst) begin
            shift_reg <= 128'h0;
            count_reg <= 4'h0;
            o_busy <= 1'b0;
            o_valid <= 1'b0;
            o_data <= 8'h00;
            o_last <= 1'b0;
        end else if (!o_busy) begin
            if (i_start) begin
                shift_reg <= {8'h00, i_frame[127:8]};
                count_reg <= 4'h0;
                o_busy <= 1'b1;
                o_valid <= 1'b1;
                o_data <= i_frame[7:0];
                o_last <= 1'b0;
            end
        end else if (o_valid && i_ready) begin
            if (o_last) begin
                o_busy <= 1'b0;
                o_valid <= 1'b0;
                o_last <= 1'b0;
            end else begin
                o_data <= shift_reg[7:0];
                shift_reg <= {8'h00, shift_reg[127:8]};
                count_reg <= count_reg + 4'h1;
                o_last <= (count_reg == 4'hE);
            end
        end
    end

endmodule
`default_nettype wire

/* src/dp_slave_diagnostic_frame.v */
// Diagnostic frame builder of a fieldbus slave with its CPU process image block.
// Assumes station status inputs come from logic on the same core clock.
`timescale 1ns/100ps
`default_nettype none
`include "dp_diag_map.vh"

module dp_slave_diagnostic_frame #(
    parameter PI_AW = 5
) (
    // Clock and reset
    input wire i_core_clk,
    input wire i_rst,
    // Register port
    input wire [7:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [7:0] o_rdata,
    output reg o_irq,
    // Station status from the protocol engine
    input wire i_not_ready,
    input wire i_cfg_mismatch,
    input wire i_unsupported,
    input wire i_param_fault,
    input wire i_new_param,
    input wire i_static_diag,
    input wire i_resp_monitor,
    input wire i_freeze_rx,
    input wire i_sync_rx,
    input wire i_overflow,
    input wire [7:0] i_master_addr,
    input wire [15:0] i_ident,
    // Error event from the protocol engine
    input wire i_err_event,
    input wire [7:0] i_err_code,
    // Master side
    input wire i_diag_req,
    output wire o_tx_valid,
    output wire [7:0] o_tx_data,
    output wire o_tx_last,
    input wire i_tx_ready,
    output reg o_unsolicited
);

    localparam PI_DEPTH = 1 << PI_AW;

    localparam ST_IDLE = 3'b001;
    localparam ST_SEND = 3'b010;
    localparam ST_DONE = 3'b100;

    ////////////////////////////////////////////////////////////////////////////
    // State

    reg [7:0] pi_mem [0:PI_DEPTH-1];
    reg [7:0] ctrl_reg;
    reg [7:0] base_reg;
    reg [7:0] irq_stat_reg;
    reg [7:0] irq_mask_reg;
    reg [7:0] msg_code_reg;
    reg [7:0] prev_stat_reg;
    reg user_valid_reg;
    reg [39:0] user_reg;
    reg req_pend_reg;
    reg evt_pend_reg;
    reg copy_pend_reg;
    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [7:0] irq_set;
    reg [7:0] stat_byte;
    reg start_evt;
    reg delete_evt;
    reg ignore_evt;
    reg err_ok;
    reg [127:0] frame;
    wire tx_busy;
    wire tx_start;
    integer k;

    // Image index of byte n of the block; wraps at the end of the image
    function [PI_AW-1:0] blk_idx;
        input [7:0] base;
        input [2:0] n;
        reg [7:0] sum;
        begin
            sum = base + {5'h00, n};
            blk_idx = sum[PI_AW-1:0];
        end
    endfunction

    function is_err_code;
        input [7:0] code;
        begin
            is_err_code = (code >= `MSG_ERR_FIRST) && (code <= `MSG_ERR_LAST);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Diagnostic status byte watch

    always @* begin
        stat_byte = pi_mem[blk_idx(base_reg, 3'd0)];
        ignore_evt = 1'b0;
        start_evt = 1'b0;
        delete_evt = 1'b0;
        if (stat_byte != prev_stat_reg) begin
            if (stat_byte == `STAT_IGNORED) begin
                ignore_evt = 1'b1;
            end else begin
                // Reserved bits are not looked at, only valid and delete
                start_evt = stat_byte[`STAT_VALID] && !prev_stat_reg[`STAT_VALID];
                delete_evt = stat_byte[`STAT_DELETE] && !prev_stat_reg[`STAT_DELETE]
                    && !stat_byte[`STAT_VALID];
            end
        end
        err_ok = i_err_event && is_err_code(i_err_code);
    end

    always @(posedge i_core_clk) begin
        if (i_rst) begin
            prev_stat_reg <= 8'h00;
        end else if (i_wr && i_addr == `REG_BASE) begin
            // A base move must not look like a status change
            prev_stat_reg <= pi_mem[blk_idx(i_wdata, 3'd0)];
        end else begin
            prev_stat_reg <= stat_byte;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Process image and user data

    always @(posedge i_core_clk) begin
        if (i_rst) begin
            for (k = 0; k < PI_DEPTH; k = k + 1) begin
                pi_mem[k] <= 8'h00;
            end
            copy_pend_reg <= 1'b0;
        end else begin
            if (i_wr && i_addr <= `PI_LAST_ADDR && i_addr < PI_DEPTH) begin
                pi_mem[i_addr[PI_AW-1:0]] <= i_wdata;
            end
            // Device copy waits for a cycle free of CPU image writes
            if (copy_pend_reg && !(i_wr && i_addr <= `PI_LAST_ADDR)) begin
                for (k = 1; k < `BLOCK_BYTES; k = k + 1) begin
                    pi_mem[blk_idx(base_reg, k[2:0])] <= user_reg[8*(k-1) +: 8];
                end
                copy_pend_reg <= err_ok;
            end else if (err_ok) begin
                copy_pend_reg <= 1'b1;
            end
        end
    end

    always @(posedge i_core_clk) begin
        if (i_rst) begin
            user_valid_reg <= 1'b0;
            user_reg <= 40'h0;
        end else if (start_evt) begin
            user_valid_reg <= 1'b1;
            for (k = 1; k < `BLOCK_BYTES; k = k + 1) begin
                user_reg[8*(k-1) +: 8] <= pi_mem[blk_idx(base_reg, k[2:0])];
            end
        end else if (delete_evt) begin
            user_valid_reg <= 1'b0;
            user_reg <= 40'h0;
        end
    end

    // Message code: a new error wins over user data state
    always @(posedge i_core_clk) begin
        if (i_rst) begin
            msg_code_reg <= `MSG_NONE;
        end else if (err_ok) begin
            msg_code_reg <= i_err_code;
        end else if (start_evt && !is_err_code(msg_code_reg)) begin
            msg_code_reg <= `MSG_USER_VALID;
        end else if (delete_evt && msg_code_reg == `MSG_USER_VALID) begin
            msg_code_reg <= `MSG_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Frame assembly

    always @* begin
        frame = 128'h0;
        frame[7:0] = {1'b0, i_param_fault, 1'b0, i_unsupported,
            (user_valid_reg || is_err_code(msg_code_reg)),
            i_cfg_mismatch, i_not_ready, 1'b0};
        frame[15:8] = {2'b00, i_sync_rx, i_freeze_rx, i_resp_monitor,
            1'b0, i_static_diag, i_new_param};
        frame[15:8] = frame[15:8] | `ST1_FIXED_ONE;
        frame[23:16] = {i_overflow, 7'h00};
        frame[31:24] = i_master_addr;
        if (ctrl_reg[`CTRL_IDENT_LOW_FIRST]) begin
            frame[47:32] = i_ident;
        end else begin
            frame[47:32] = {i_ident[7:0], i_ident[15:8]};
        end
        frame[55:48] = `DEV_LEN_TYPE;
        frame[63:56] = msg_code_reg;
        frame[87:64] = 24'h0;
        frame[127:88] = user_valid_reg ? user_reg : 40'h0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Send control

    assign tx_start = (state_reg == ST_IDLE) && (req_pend_reg || evt_pend_reg) && !tx_busy;

    always @* begin
        case (state_reg)
            ST_IDLE: begin
                state_next = tx_start ? ST_SEND : ST_IDLE;
            end
            ST_SEND: begin
                state_next = tx_busy ? ST_SEND : ST_DONE;
            end
            ST_DONE: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always @(posedge i_core_clk) begin
        if (i_rst) begin
            state_reg <= ST_IDLE;
            req_pend_reg <= 1'b0;
            evt_pend_reg <= 1'b0;
            o_unsolicited <= 1'b0;
        end else begin
            state_reg <= state_next;
            // New requests during a send are kept for the next frame
            if (i_diag_req) begin
                req_pend_reg <= 1'b1;
            end else if (tx_start) begin
                req_pend_reg <= 1'b0;
            end
            if (err_ok || start_evt || delete_evt) begin
                evt_pend_reg <= 1'b1;
            end else if (tx_start) begin
                evt_pend_reg <= 1'b0;
            end
            if (tx_start) begin
                o_unsolicited <= !req_pend_reg;
            end
        end
    end

    diag_frame_tx u_tx (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_start(tx_start),
        .i_frame(frame),
        .o_busy(tx_busy),
        .o_valid(o_tx_valid),
        .o_data(o_tx_data),
        .o_last(o_tx_last),
        .i_ready(i_tx_ready)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Registers and interrupt

    always @* begin
        irq_set = 8'h00;
        irq_set[`IRQ_FRAME_SENT] = (state_reg == ST_DONE);
        irq_set[`IRQ_USER_START] = start_evt;
        irq_set[`IRQ_USER_DELETE] = delete_evt;
        irq_set[`IRQ_ERROR] = err_ok;
        irq_set[`IRQ_IGNORED] = ignore_evt;
    end

    always @(posedge i_core_clk) begin
        if (i_rst) begin
            ctrl_reg <= `CTRL_RESET;
            base_reg <= `BASE_RESET;
            irq_mask_reg <= `MASK_RESET;
        end else if (i_wr) begin
            case (i_addr)
                `REG_CTRL: begin
                    ctrl_reg <= i_wdata & 8'h01;
                end
                `REG_BASE: begin
                    base_reg <= i_wdata;
                end
                `REG_IRQ_MASK: begin
                    irq_mask_reg <= i_wdata & 8'h1F;
                end
                default: begin
                end
            endcase
        end
    end

    // A read clears the status, but an event in the same cycle survives
    always @(posedge i_core_clk) begin
        if (i_rst) begin
            irq_stat_reg <= 8'h00;
        end else if (i_rd && i_addr == `REG_IRQ_STAT) begin
            irq_stat_reg <= irq_set;
        end else begin
            irq_stat_reg <= irq_stat_reg | irq_set;
        end
    end

    always @(posedge i_core_clk) begin
        if (i_rst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    always @(posedge i_core_clk) begin
        if (i_rst) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            if (i_addr <= `PI_LAST_ADDR) begin
                o_rdata <= (i_addr < PI_DEPTH) ? pi_mem[i_addr[PI_AW-1:0]] : 8'h00;
            end else begin
                case (i_addr)
                    `REG_CTRL: begin
                        o_rdata <= ctrl_reg;
                    end
                    `REG_BASE: begin
                        o_rdata <= base_reg;
                    end
                    `REG_IRQ_STAT: begin
                        o_rdata <= irq_stat_reg;
                    end
                    `REG_IRQ_MASK: begin
                        o_rdata <= irq_mask_reg;
                    end
                    `REG_MSG_CODE: begin
                        o_rdata <= msg_code_reg;
                    end
                    `REG_STATE: begin
                        o_rdata <= {4'h0, copy_pend_reg, evt_pend_reg, tx_busy, user_valid_reg};
                    end
                    default: begin
                        o_rdata <= 8'h00;
                    end
                endcase
            end
        end else begin
            o_rdata <= 8'h00;
        end
    end

endmodule
`default_nettype wire

/* sim/dp_diag_monitor.sv */
// Checker for the diagnostic frame stream of the frame builder.
// Assumes one core clock and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module dp_diag_monitor (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // Master side
    input wire logic i_diag_req,
    input wire logic i_tx_ready,
    input wire logic [7:0] i_master_addr,
    input wire logic o_tx_valid,
    input wire logic [7:0] o_tx_data,
    input wire logic o_tx_last,
    input wire logic o_unsolicited
);
    logic [3:0] idx_reg;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    // Byte position; wraps to zero after byte 15, so no frame end is needed
    always @(posedge i_core_clk) begin
        if (i_rst) begin
            idx_reg <= 4'h0;
        end else if (o_tx_valid && i_tx_ready) begin
            idx_reg <= idx_reg + 4'h1;
        end
    end
    ////////////////////////////////////////
    chk_hold_byte: assert property (
        o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
        else $error("byte changed before accept");
    chk_req_served: assert property (
        i_diag_req && !o_tx_valid |-> ##[1:6] o_tx_valid)
        else $error("request not served");
    chk_stat0_zero: assert property (
        o_tx_valid && idx_reg == 4'h0 |-> (o_tx_data & 8'hA1) == 8'h00)
        else $error("byte 0 fixed bits");
    chk_stat1_fix: assert property (
        o_tx_valid && idx_reg == 4'h1 |-> (o_tx_data & 8'hC4) == 8'h04)
        else $error("byte 1 fixed bits");
    chk_stat2_res: assert property (
        o_tx_valid && idx_reg == 4'h2 |-> (o_tx_data & 8'h7F) == 8'h00)
        else $error("byte 2 reserved bits");
    chk_master_addr: assert property (
        o_tx_valid && idx_reg == 4'h3 |-> o_tx_data == i_master_addr)
        else $error("byte 3 master address");
    chk_len_code: assert property (
        o_tx_valid && idx_reg == 4'h6 |-> o_tx_data == 8'h0A)
        else $error("byte 6 length code");
    chk_msg_code: assert property (
        o_tx_valid && idx_reg == 4'h7
        |-> o_tx_data inside {8'h00, [8'h12:8'h17], 8'h40}) else $error("byte 7 code");
    chk_rsvd_bytes: assert property (
        o_tx_valid && idx_reg inside {[4'h8:4'hA]} |-> o_tx_data == 8'h00)
        else $error("reserved byte not zero");
    chk_last_byte: assert property (
        o_tx_valid |-> o_tx_last == (idx_reg == 4'hF)) else $error("last flag misplaced");
    cov_stall: cover property (o_tx_valid && !i_tx_ready);
    cov_unsol: cover property (o_tx_last && o_unsolicited);
    cov_polled: cover property (o_tx_last && !o_unsolicited);
endmodule
bind dp_slave_diagnostic_frame dp_diag_monitor u_mon (.i_core_clk(i_core_clk),
    .i_rst(i_rst), .i_diag_req(i_diag_req), .i_tx_ready(i_tx_ready),
    .i_master_addr(i_master_addr), .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data),
    .o_tx_last(o_tx_last), .o_unsolicited(o_unsolicited));
`default_nettype wire

/* sim/dp_master_model.sv */
// Master side model: takes frame bytes and keeps the last whole frame.
// Assumes a byte is taken when valid and ready are both high.
`timescale 1ns/100ps
`default_nettype none
module dp_master_model (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // Slow mode toggles ready to stall the sender
    input wire logic i_slow,
    // Byte stream
    input wire logic i_valid,
    input wire logic [7:0] i_data,
    input wire logic i_last,
    output logic o_ready,
    // Collected frame
    output logic [127:0] o_frame,
    output int o_frames
);
    logic [3:0] idx_reg;
    always @(posedge i_core_clk) begin
        if (i_rst) begin
            o_ready <= 1'b0;
            idx_reg <= 4'h0;
            o_frames <= 0;
        end else begin
            o_ready <= i_slow ? ~o_ready : 1'b1;
            if (i_valid && o_ready) begin
                o_frame[{idx_reg, 3'b000} +: 8] <= i_data;
                idx_reg <= i_last ? 4'h0 : idx_reg + 4'h1;
                if (i_last) o_frames <= o_frames + 1;
            end
        end
    end
endmodule
`default_nettype wire

/* sim/testbench.sv */
// Testbench: register tasks, master model and whole-frame compares.
// Assumes the frame builder, monitor and master model are compiled with it.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
    $display("mismatch %s exp %0h got %0h", n, e, g); end end
module testbench;
    logic clk = 0, rst = 1, wr_s = 0, rd_s = 0, dreq = 0, eev = 0, slow = 0, lf = 0;
    logic [7:0] addr = 0, wd = 0, ecode = 0, maddr = 8'h5A, rdata, tdata;
    logic [9:0] st = 10'h2A5;
    logic [15:0] ident = 16'hC3A5;
    logic [39:0] u = 40'h5544332211;
    logic irq, tvalid, tlast, tready, unsol;
    logic [127:0] fr;
    int frames, n, failures = 0, total_checks = 0;
    always #2.5 clk = ~clk;
    dp_slave_diagnostic_frame u_dut (.i_core_clk(clk), .i_rst(rst), .i_addr(addr),
        .i_wdata(wd), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .o_irq(irq),
        .i_not_ready(st[0]), .i_cfg_mismatch(st[1]), .i_unsupported(st[2]),
        .i_param_fault(st[3]), .i_new_param(st[4]), .i_static_diag(st[5]),
        .i_resp_monitor(st[6]), .i_freeze_rx(st[7]), .i_sync_rx(st[8]),
        .i_overflow(st[9]), .i_master_addr(maddr), .i_ident(ident), .i_err_event(eev),
        .i_err_code(ecode), .i_diag_req(dreq), .o_tx_valid(tvalid), .o_tx_data(tdata),
        .o_tx_last(tlast), .i_tx_ready(tready), .o_unsolicited(unsol));
    dp_master_model u_master (.i_core_clk(clk), .i_rst(rst), .i_slow(slow),
        .i_valid(tvalid), .i_data(tdata), .i_last(tlast), .o_ready(tready),
        .o_frame(fr), .o_frames(frames));
    ////////////////////////////////////////
    function automatic [127:0] efr(input [7:0] m, input uv, input [39:0] us);
        logic ext;
        ext = uv | (m >= 8'h12 && m <= 8'h17);
        return {us, 24'h0, m, 8'h0A, lf ? ident : {ident[7:0], ident[15:8]}, maddr,
            st[9], 7'h0, 2'b0, st[8:6], 1'b1, st[5:4], 1'b0, st[3], 1'b0, st[2], ext,
            st[1:0], 1'b0};
    endfunction
    task wr(input [7:0] a, d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr_s <= 1;
        @(posedge clk);
        wr_s <= 0;
    endtask
    task rd(input [7:0] a, e, mk);
        @(posedge clk);
        addr <= a;
        rd_s <= 1;
        @(posedge clk);
        rd_s <= 0;
        @(negedge clk);
        `CHK("rdata", e, rdata & mk)
    endtask
    task ev(input r, input [7:0] c);
        @(posedge clk);
        dreq <= r;
        eev <= !r;
        ecode <= c;
        @(posedge clk);
        dreq <= 0;
        eev <= 0;
    endtask
    task frame(input [7:0] m, input uv, input [39:0] us, input un);
        int k;
        k = frames;
        for (int i = 0; i < 300 && frames == k; i++) @(negedge clk);
        `CHK("frames", k + 1, frames)
        `CHK("frame", efr(m, uv, us), fr)
        `CHK("unsol", un, unsol)
    endtask
    // A refused trigger must leave the frame count alone
    task quiet;
        n = frames;
        repeat (20) @(negedge clk);
        `CHK("frames", n, frames)
    endtask
    task print_verdict;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        #100000;
        failures++;
        print_verdict;
    end
    initial begin
        repeat (2) @(posedge clk);
        rst <= 0;
        for (int a = 8'h20; a < 8'h26; a++) rd(8'(a), 8'h00, 8'hFF);
        rd(8'h30, 8'h00, 8'hFF);
        wr(8'h23, 8'h1F);
        ev(1, 8'h00);
        frame(8'h00, 0, 40'h0, 0);
        repeat (3) @(negedge clk);
        `CHK("irq", 1'b1, irq)
        wr(8'h23, 8'h00);
        repeat (3) @(negedge clk);
        `CHK("irq", 1'b0, irq)
        wr(8'h23, 8'h1F);
        rd(8'h22, 8'h01, 8'h01);
        repeat (3) @(negedge clk);
        `CHK("irq", 1'b0, irq)
        // Block base at 1E so the user bytes wrap past the image end
        wr(8'h21, 8'h1E);
        for (int i = 0; i < 5; i++) wr(8'((31 + i) % 32), u[8*i +: 8]);
        wr(8'h1E, 8'h01);
        frame(8'h40, 1, u, 1);
        rd(8'h24, 8'h40, 8'hFF);
        rd(8'h25, 8'h01, 8'h01);
        wr(8'h1E, 8'h00);
        wr(8'h1E, 8'h03);
        quiet;
        rd(8'h22, 8'h10, 8'h10);
        wr(8'h1E, 8'h00);
        wr(8'h1E, 8'h02);
        frame(8'h00, 0, 40'h0, 1);
        rd(8'h25, 8'h00, 8'h01);
        wr(8'h1E, 8'h00);
        wr(8'h1E, 8'h01);
        frame(8'h40, 1, u, 1);
        wr(8'h1F, 8'hAA);
        for (int c = 8'h12; c <= 8'h17; c++) begin
            ev(0, 8'(c));
            frame(8'(c), 1, u, 1);
        end
        rd(8'h22, 8'h0F, 8'h1F);
        rd(8'h1F, 8'h11, 8'hFF);
        ev(0, 8'h18);
        quiet;
        @(posedge clk);
        st <= ~st;
        lf <= 1;
        wr(8'h20, 8'h01);
        slow <= 1;
        ev(1, 8'h00);
        frame(8'h17, 1, u, 0);
        print_verdict;
    end
endmodule
`default_nettype wire
